// [hw/iblc_loop_code.sv]
// in-band loop code generator, two detectors and their registers
// Behaviour
// - transmit length: 00 five, 01 six, 10 seven, 11 sixteen bits
// - pattern replaces transmit data only while transmit enable is set
// - bit 7 of the low transmit byte goes out first
// - unused low byte bits are skipped for lengths five to seven
// - high transmit byte holds pattern bits 7 down to 0
// - separate loop-up and loop-down detectors, each with two bytes
// - receive length codes 0-6 give 1-7 bits, code 7 gives 16
// - length control: transmit 7:6, loop-up 5:3, loop-down 2:0
// - receive lengths 1-7 compare only top bits of the low byte
// - bit 7 of each low receive byte is the first compared bit
// - detection survives one bit error per hundred
// - after 48 ms integration set loop-up status 7 or loop-down 6
// - detect bits stay latched; interrupt only where mask bit is 1
// - auto remote loopback after 5 s up, held until 5 s down
`timescale 1ns/1ps
`include "iblc_map.svh"

module iblc_loop_code #(
  parameter int unsigned INTEG_CYC = `IBLC_INTEG_CYC,
  parameter int unsigned HOLD_CYC = `IBLC_HOLD_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire iblc_pkg::iblc_bus_req_t busReq,
  output logic [7:0] rdData,
  input wire logic txBitStrobe,
  input wire logic txDataIn,
  output logic txDataOut,
  input wire logic rxBitValid,
  input wire logic rxBit,
  output logic intReq,
  output logic remoteLoopback
);

  logic [7:0] ctrl3_reg;
  logic [7:0] ctrl6_reg;
  logic [7:0] mask_reg;
  logic [7:0] lenCtl_reg;
  logic [7:0] txLo_reg;
  logic [7:0] txHi_reg;
  logic [7:0] upLo_reg;
  logic [7:0] upHi_reg;
  logic [7:0] dnLo_reg;
  logic [7:0] dnHi_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic remoteLoop_reg;
  logic [31:0] holdCnt_reg;
  logic [3:0] txIdx_reg;
  logic [4:0] txLen;
  logic [15:0] txWord;
  logic txEnable;
  logic upPresent;
  logic dnPresent;
  logic statusRead;
  logic [7:0] rdMux;

  // register writes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl3_reg <= `IBLC_RESET_BYTE;
      ctrl6_reg <= `IBLC_RESET_BYTE;
      mask_reg <= `IBLC_RESET_BYTE;
      lenCtl_reg <= `IBLC_RESET_BYTE;
      txLo_reg <= `IBLC_RESET_BYTE;
      txHi_reg <= `IBLC_RESET_BYTE;
      upLo_reg <= `IBLC_RESET_BYTE;
      upHi_reg <= `IBLC_RESET_BYTE;
      dnLo_reg <= `IBLC_RESET_BYTE;
      dnHi_reg <= `IBLC_RESET_BYTE;
    end else if (busReq.wr) begin
      case (busReq.addr)
        `IBLC_OFF_CTRL3: ctrl3_reg <= busReq.data;
        `IBLC_OFF_CTRL6: ctrl6_reg <= busReq.data;
        `IBLC_OFF_MASK: mask_reg <= busReq.data;
        `IBLC_OFF_LENCTL: lenCtl_reg <= busReq.data;
        `IBLC_OFF_TXLO: txLo_reg <= busReq.data;
        `IBLC_OFF_TXHI: txHi_reg <= busReq.data;
        `IBLC_OFF_UPLO: upLo_reg <= busReq.data;
        `IBLC_OFF_UPHI: upHi_reg <= busReq.data;
        `IBLC_OFF_DNLO: dnLo_reg <= busReq.data;
        `IBLC_OFF_DNHI: dnHi_reg <= busReq.data;
        default: ;
      endcase
    end
  end

  // read mux, unmapped offsets read zero
  always_comb begin
    case (busReq.addr)
      `IBLC_OFF_CTRL3: rdMux = ctrl3_reg;
      `IBLC_OFF_CTRL6: rdMux = ctrl6_reg;
      `IBLC_OFF_STATUS: rdMux = {status_reg, 6'h00};
      `IBLC_OFF_MASK: rdMux = mask_reg;
      `IBLC_OFF_RXINFO2: rdMux = {6'h00, remoteLoop_reg, 1'b0};
      `IBLC_OFF_LENCTL: rdMux = lenCtl_reg;
      `IBLC_OFF_TXLO: rdMux = txLo_reg;
      `IBLC_OFF_TXHI: rdMux = txHi_reg;
      `IBLC_OFF_UPLO: rdMux = upLo_reg;
      `IBLC_OFF_UPHI: rdMux = upHi_reg;
      `IBLC_OFF_DNLO: rdMux = dnLo_reg;
      `IBLC_OFF_DNHI: rdMux = dnHi_reg;
      default: rdMux = 8'h00;
    endcase
  end

  // read data register, updated on each read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdData <= 8'h00;
    end else if (busReq.rd) begin
      rdData <= rdMux;
    end
  end

  // transmit pattern: low byte first, its bit 7 leads
  assign txEnable = ctrl3_reg[`IBLC_BIT_TX_EN];
  assign txLen = iblc_pkg::iblcTxLen(
    lenCtl_reg[`IBLC_TXLEN_HI:`IBLC_TXLEN_LO]);
  assign txWord = {txLo_reg, txHi_reg};

  // bit index inside the pattern, restarts when disabled
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txIdx_reg <= 4'h0;
    end else if (!txEnable) begin
      txIdx_reg <= 4'h0;
    end else if (txBitStrobe) begin
      if ({1'b0, txIdx_reg} >= txLen - 5'h01) begin
        txIdx_reg <= 4'h0;
      end else begin
        txIdx_reg <= txIdx_reg + 4'h1;
      end
    end
  end

  // outgoing bit: pattern while enabled, else pass-through
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      txDataOut <= 1'b0;
    end else if (txBitStrobe) begin
      txDataOut <= txEnable ? txWord[4'hF - txIdx_reg] : txDataIn;
    end
  end

  // loop-up and loop-down detectors
  iblc_code_detector #(.INTEG_CYC(INTEG_CYC)) upDet (
    .clk(clk),
    .rst_b(rst_b),
    .bitValid(rxBitValid),
    .rxBit(rxBit),
    .pattern({upLo_reg, upHi_reg}),
    .patLen(iblc_pkg::iblcRxLen(
      lenCtl_reg[`IBLC_UPLEN_HI:`IBLC_UPLEN_LO])),
    .present(upPresent)
  );

  iblc_code_detector #(.INTEG_CYC(INTEG_CYC)) dnDet (
    .clk(clk),
    .rst_b(rst_b),
    .bitValid(rxBitValid),
    .rxBit(rxBit),
    .pattern({dnLo_reg, dnHi_reg}),
    .patLen(iblc_pkg::iblcRxLen(
      lenCtl_reg[`IBLC_DNLEN_HI:`IBLC_DNLEN_LO])),
    .present(dnPresent)
  );

  // latched detect bits, cleared by a status read, set wins
  assign statusRead = busReq.rd && busReq.addr == `IBLC_OFF_STATUS;
  assign status_next = (statusRead ? 2'h0 : status_reg) |
                       {upPresent, dnPresent};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_reg <= 2'h0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign intReq = |(status_reg &
    mask_reg[`IBLC_BIT_UP_DET:`IBLC_BIT_DN_DET]);

  // automatic remote loopback: 5 s of up sets, 5 s of down clears
  always_ff @(posedge clk) begin
    if (!rst_b || !ctrl6_reg[`IBLC_BIT_AUTO_RLB_EN]) begin
      remoteLoop_reg <= 1'b0;
      holdCnt_reg <= 32'h0000_0000;
    end else if (remoteLoop_reg ? dnPresent : upPresent) begin
      if (holdCnt_reg >= HOLD_CYC - 1) begin
        remoteLoop_reg <= !remoteLoop_reg;
        holdCnt_reg <= 32'h0000_0000;
      end else begin
        holdCnt_reg <= holdCnt_reg + 32'h0000_0001;
      end
    end else begin
      holdCnt_reg <= 32'h0000_0000;
    end
  end

  assign remoteLoopback = remoteLoop_reg;

  // checks on generator, status and loopback, one clock domain
  default clocking mainClk @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_tx_step;
    txEnable && txBitStrobe;
  endsequence

  a_tx_pass_data: assert property (!txEnable && txBitStrobe |=>
    txDataOut == $past(txDataIn))
    else $error("disabled generator did not pass data");
  a_tx_first_bit: assert property (s_tx_step ##0
    txIdx_reg == 4'h0 |=> txDataOut == $past(txLo_reg[7]))
    else $error("first pattern bit is not low byte bit 7");
  a_tx_five_wrap: assert property (s_tx_step ##0
    lenCtl_reg[7:6] == 2'h0 && txIdx_reg == 4'h4 |=> txIdx_reg == 4'h0)
    else $error("five bit pattern did not wrap");
  a_tx_sixteen_run: assert property (s_tx_step ##0
    lenCtl_reg[7:6] == 2'h3 && txIdx_reg == 4'h7 && !busReq.wr
    |=> txIdx_reg == 4'h8)
    else $error("sixteen bit pattern stopped early");
  a_status_latch: assert property (status_reg[1] && !statusRead |=>
    status_reg[1])
    else $error("loop-up status dropped without a read");
  a_status_set: assert property ($rose(dnPresent) |=>
    status_reg[0])
    else $error("loop-down status not set on detection");
  a_int_masked: assert property (mask_reg[7:6] == 2'h0 |->
    !intReq)
    else $error("masked status raised an interrupt");
  a_rloop_forced: assert property (
    !ctrl6_reg[`IBLC_BIT_AUTO_RLB_EN] |=> !remoteLoopback)
    else $error("remote loopback set while disabled");
  a_rloop_cause: assert property ($rose(remoteLoopback) |->
    $past(upPresent))
    else $error("remote loopback set without loop-up code");

endmodule

// [include/iblc_map.svh]
// register offsets, field positions and timing counts for the loop code block
`ifndef IBLC_MAP_SVH
`define IBLC_MAP_SVH

`define IBLC_OFF_CTRL3 8'h03
`define IBLC_OFF_CTRL6 8'h05
`define IBLC_OFF_STATUS 8'h06
`define IBLC_OFF_MASK 8'h07
`define IBLC_OFF_RXINFO2 8'h09
`define IBLC_OFF_LENCTL 8'h0A
`define IBLC_OFF_TXLO 8'h0B
`define IBLC_OFF_TXHI 8'h0C
`define IBLC_OFF_UPLO 8'h0D
`define IBLC_OFF_UPHI 8'h0E
`define IBLC_OFF_DNLO 8'h0F
`define IBLC_OFF_DNHI 8'h10

`define IBLC_RESET_BYTE 8'h00
`define IBLC_BIT_TX_EN 3
`define IBLC_BIT_AUTO_RLB_EN 5
`define IBLC_BIT_UP_DET 7
`define IBLC_BIT_DN_DET 6
`define IBLC_BIT_RLOOP 1
`define IBLC_TXLEN_HI 7
`define IBLC_TXLEN_LO 6
`define IBLC_UPLEN_HI 5
`define IBLC_UPLEN_LO 3
`define IBLC_DNLEN_HI 2
`define IBLC_DNLEN_LO 0

// bits per quality block and the errors a good block may hold
`define IBLC_BLOCK_LAST 8'hFF
`define IBLC_ERR_LIMIT 5'h08

// clocks per millisecond at 250 MHz, kept small enough for 32-bit math
`define IBLC_CYC_PER_MS 250000
`define IBLC_INTEG_MS 48
`define IBLC_HOLD_S 5
`define IBLC_INTEG_CYC (`IBLC_INTEG_MS * `IBLC_CYC_PER_MS)
`define IBLC_HOLD_CYC (`IBLC_HOLD_S * 1000 * `IBLC_CYC_PER_MS)

`endif

// [include/iblc_pkg.sv]
// types and length decoders for the loop code block
package iblc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic wr;
    logic rd;
  } iblc_bus_req_t;

  typedef enum logic [1:0] {
    IBLC_SEARCH,
    IBLC_VERIFY,
    IBLC_PRESENT
  } iblc_det_state_t;

  // transmit length select to pattern length in bits
  function automatic logic [4:0] iblcTxLen(input logic [1:0] sel);
    case (sel)
      2'h0: iblcTxLen = 5'h05;
      2'h1: iblcTxLen = 5'h06;
      2'h2: iblcTxLen = 5'h07;
      default: iblcTxLen = 5'h10;
    endcase
  endfunction

  // receive length code to pattern length in bits
  function automatic logic [4:0] iblcRxLen(input logic [2:0] code);
    if (code == 3'h7) begin
      iblcRxLen = 5'h10;
    end else begin
      iblcRxLen = {2'h0, code} + 5'h01;
    end
  endfunction

endpackage

// [hw/iblc_code_detector.sv]
// one repeating loop code detector with error tolerant integration
`timescale 1ns/1ps
`include "iblc_map.svh"

module iblc_code_detector #(
  parameter int unsigned INTEG_CYC = `IBLC_INTEG_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bitValid,
  input wire logic rxBit,
  input wire logic [15:0] pattern,
  input wire logic [4:0] patLen,
  output logic present
);

  logic [3:0] phase_reg;
  logic [7:0] blkCnt_reg;
  logic [4:0] errCnt_reg;
  logic [31:0] timer_reg;
  iblc_pkg::iblc_det_state_t state_reg;
  logic mismatch;
  logic [4:0] errNext;
  logic blockEnd;
  logic blockBad;

  // expected bit, first bit at pattern msb
  assign mismatch = rxBit != pattern[4'hF - phase_reg];
  assign errNext = (mismatch && errCnt_reg != 5'h1F) ?
                   errCnt_reg + 5'h01 : errCnt_reg;
  assign blockEnd = bitValid && blkCnt_reg == `IBLC_BLOCK_LAST;
  assign blockBad = errNext > `IBLC_ERR_LIMIT;
  assign present = state_reg == iblc_pkg::IBLC_PRESENT;

  // phase within the pattern, held one bit on a bad block to slip
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      phase_reg <= 4'h0;
    end else if (bitValid && !(blockEnd && blockBad)) begin
      if ({1'b0, phase_reg} >= patLen - 5'h01) begin
        phase_reg <= 4'h0;
      end else begin
        phase_reg <= phase_reg + 4'h1;
      end
    end
  end

  // bit and error counts per quality block
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blkCnt_reg <= 8'h00;
      errCnt_reg <= 5'h00;
    end else if (bitValid) begin
      blkCnt_reg <= blkCnt_reg + 8'h01;
      errCnt_reg <= blockEnd ? 5'h00 : errNext;
    end
  end

  // integration state
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_reg <= iblc_pkg::IBLC_SEARCH;
      timer_reg <= 32'h0000_0000;
    end else begin
      case (state_reg)
        iblc_pkg::IBLC_SEARCH: begin
          timer_reg <= 32'h0000_0000;
          if (blockEnd && !blockBad) begin
            state_reg <= iblc_pkg::IBLC_VERIFY;
          end
        end
        iblc_pkg::IBLC_VERIFY: begin
          timer_reg <= timer_reg + 32'h0000_0001;
          if (blockEnd && blockBad) begin
            state_reg <= iblc_pkg::IBLC_SEARCH;
          end else if (timer_reg >= INTEG_CYC - 1) begin
            state_reg <= iblc_pkg::IBLC_PRESENT;
          end
        end
        iblc_pkg::IBLC_PRESENT: begin
          if (blockEnd && blockBad) begin
            state_reg <= iblc_pkg::IBLC_SEARCH;
          end
        end
        default: state_reg <= iblc_pkg::IBLC_SEARCH;
      endcase
    end
  end

  // checks on the detector, all in the one clock domain
  default clocking detClk @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_bad_block;
    blockEnd && blockBad;
  endsequence

  a_det_bad_drop: assert property (s_bad_block |=>
    state_reg == iblc_pkg::IBLC_SEARCH)
    else $error("bad block did not restart search");
  a_det_integ_time: assert property ($rose(present) |->
    $past(timer_reg) >= INTEG_CYC - 1)
    else $error("code reported before integration ended");
  a_det_phase_wrap: assert property ({1'b0, phase_reg} < patLen |=>
    {1'b0, phase_reg} < patLen)
    else $error("detector phase left the pattern length");

endmodule

// [dv/iblc_remote_line.sv]
// remote line model that sends a repeating loop code
`timescale 1ns/1ps
module iblc_remote_line (
  input wire logic clk,
  input wire logic run,
  input wire logic slow,
  input wire logic [15:0] word,
  input wire logic [4:0] len,
  output logic rxBitValid,
  output logic rxBit
);
  int idx = 0;
  int cnt = 0;
  logic ph = 1'b0;
  initial rxBit = 1'b0;
  initial rxBitValid = 1'b0;
  // one bit per cycle, or every other cycle when slow
  always @(negedge clk) begin
    ph <= ~ph;
    rxBitValid <= run && (!slow || ph);
    if (run && (!slow || ph)) begin
      // word msb first, one inverted bit in every hundred
      rxBit <= word[15 - idx] ^ (cnt == 99);
      idx <= (idx + 1 >= len) ? 0 : idx + 1;
      cnt <= (cnt == 99) ? 0 : cnt + 1;
    end else begin
      rxBit <= ~rxBit; // no stale level between bits
    end
  end
endmodule

// [dv/iblc_loop_code_tb.sv]
// self-checking bench for the loop code block
`timescale 1ns/1ps
module iblc_loop_code_tb;
  logic clk;
  logic rst_b;
  iblc_pkg::iblc_bus_req_t busReq;
  logic [7:0] rdData;
  logic txBitStrobe, txDataIn, txDataOut;
  logic rxBitValid, rxBit, intReq, remoteLoopback;
  logic run, slow;
  logic [15:0] rxWord;
  logic [4:0] rxLen;
  int failures = 0;
  int compares = 0;

  iblc_loop_code #(.INTEG_CYC(50), .HOLD_CYC(100)) i_iblc_loop_code (
    .clk(clk), .rst_b(rst_b), .busReq(busReq), .rdData(rdData),
    .txBitStrobe(txBitStrobe), .txDataIn(txDataIn),
    .txDataOut(txDataOut), .rxBitValid(rxBitValid), .rxBit(rxBit),
    .intReq(intReq), .remoteLoopback(remoteLoopback));

  iblc_remote_line i_iblc_remote_line (.clk(clk), .run(run),
    .slow(slow), .word(rxWord), .len(rxLen),
    .rxBitValid(rxBitValid), .rxBit(rxBit));

  // free running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic end_of_test();
    if (failures == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    busReq = '{addr: a, data: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    busReq.wr = 1'b0;
  endtask

  // one-cycle read strobe, data judged a cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    busReq = '{addr: a, data: 8'h00, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    busReq.rd = 1'b0;
    chk(rdData, exp);
  endtask

  // bounded wait for a level on a design output
  task automatic wait_for(ref logic sig, input logic val);
    int n;
    n = 0;
    while (sig !== val && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(sig, val);
  endtask

  // reset values, readback, read-only and unmapped places
  task automatic test_regs();
    for (int i = 3; i < 18; i++) rd(8'(i), 8'h00);
    for (int i = 10; i < 17; i++) wr(8'(i), 8'(8'hA0 + i));
    for (int i = 10; i < 17; i++) rd(8'(i), 8'(8'hA0 + i));
    wr(8'h06, 8'hFF);
    rd(8'h06, 8'h00);
    wr(8'h11, 8'hFF);
    rd(8'h11, 8'h00);
  endtask

  // generator output over three repetitions, strobes back to back
  task automatic test_tx(input logic [1:0] sel, input logic [7:0] lo,
      input logic [7:0] hi, input int len);
    logic [15:0] w;
    w = {lo, hi};
    wr(8'h0A, {sel, 6'h00});
    wr(8'h0B, lo);
    wr(8'h0C, hi);
    wr(8'h03, 8'h08);
    txDataIn = 1'b1;
    txBitStrobe = 1'b1;
    for (int i = 0; i < 3 * len; i++) begin
      @(negedge clk);
      chk_bit(txDataOut, w[15 - i % len]);
    end
    txBitStrobe = 1'b0;
    wr(8'h03, 8'h00);
  endtask

  // with enable clear the upstream data passes and then stands
  task automatic test_pass();
    txBitStrobe = 1'b1;
    for (int i = 0; i < 4; i++) begin
      txDataIn = i[0];
      @(negedge clk);
      chk_bit(txDataOut, i[0]);
    end
    txBitStrobe = 1'b0;
    txDataIn = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(txDataOut, 1'b1);
  endtask

  // loop-up then loop-down code with line errors and auto loopback
  task automatic test_rx();
    wr(8'h0A, 8'h27);
    wr(8'h0D, 8'h87);
    wr(8'h0F, 8'hCA);
    wr(8'h10, 8'h53);
    wr(8'h07, 8'h80);
    wr(8'h05, 8'h20);
    rxWord = 16'h8000;
    rxLen = 5'h05;
    run = 1'b1;
    wait_for(intReq, 1'b1);
    chk_bit(remoteLoopback, 1'b0);
    rd(8'h06, 8'h80);
    wait_for(remoteLoopback, 1'b1);
    rd(8'h09, 8'h02);
    wr(8'h07, 8'h40);
    rxWord = 16'hCA53;
    rxLen = 5'h10;
    slow = 1'b1;
    wait_for(intReq, 1'b1);
    wait_for(remoteLoopback, 1'b0);
    rd(8'h06, 8'hC0);
    rd(8'h06, 8'h40);
    rd(8'h09, 8'h00);
    wr(8'h07, 8'h80);
    chk_bit(intReq, 1'b0);
  endtask

  // mid-run reset returns registers and outputs to zero
  task automatic test_reset();
    run = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk_bit(txDataOut, 1'b0);
    chk_bit(remoteLoopback, 1'b0);
    rd(8'h0A, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h0B, 8'h00);
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    busReq = '0;
    txBitStrobe = 1'b0;
    txDataIn = 1'b0;
    run = 1'b0;
    slow = 1'b0;
    rxWord = 16'h0000;
    rxLen = 5'h01;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    test_regs();
    test_tx(2'h0, 8'h87, 8'hFF, 5);
    test_tx(2'h1, 8'h83, 8'hFF, 6);
    test_tx(2'h2, 8'h81, 8'hFF, 7);
    test_tx(2'h3, 8'hA5, 8'h3C, 16);
    test_pass();
    test_rx();
    test_reset();
    end_of_test();
  end

  // watchdog against a hang
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule
